/* pkg/spd_pkg.sv */
// Constants for the strap-pin motor configuration decoder.
// Assumes the register bank sits inside the decoder and reads back the written bank values plus a status word and the synchronised strap word.
package spd_pkg;
   // -----------------------------------------------------------------
   // APB register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_AMPL     = 8'h00;
   localparam logic [7:0] ADDR_STEP     = 8'h04;
   localparam logic [7:0] ADDR_STDBY    = 8'h08;
   localparam logic [7:0] ADDR_REG_TGT  = 8'h0C;
   localparam logic [7:0] ADDR_REG_GAIN = 8'h10;
   localparam logic [7:0] ADDR_FS_THRS  = 8'h14;
   localparam logic [7:0] ADDR_FS_CUR   = 8'h18;
   localparam logic [7:0] ADDR_DECAY    = 8'h1C;
   localparam logic [7:0] ADDR_STATUS   = 8'h20;
   localparam logic [7:0] ADDR_STRAPS   = 8'h24;
   // -----------------------------------------------------------------
   // Register bank reset values
   // -----------------------------------------------------------------
   localparam logic [7:0]  RST_AMPL     = 8'hFF;
   localparam logic [7:0]  RST_STEP     = 8'h01;
   localparam logic [1:0]  RST_STDBY    = 2'h0;
   localparam logic [7:0]  RST_REG_TGT  = 8'h00;
   localparam logic [15:0] RST_REG_GAIN = 16'h0008;
   localparam logic [7:0]  RST_FS_THRS  = 8'h00;
   localparam logic [3:0]  RST_FS_CUR   = 4'h2;
   localparam logic [1:0]  RST_DECAY    = 2'h0;
   // -----------------------------------------------------------------
   // Decode constants
   // -----------------------------------------------------------------
   localparam logic [3:0]  AMPL_LOW_NIBBLE = 4'hF;
   localparam logic [7:0]  STEP_INC0 = 8'h01;
   localparam logic [7:0]  STEP_INC1 = 8'h04;
   localparam logic [7:0]  STEP_INC2 = 8'h10;
   localparam logic [7:0]  STEP_INC3 = 8'h40;
   localparam logic [7:0]  TGT_1 = 8'h28;
   localparam logic [7:0]  TGT_2 = 8'h3C;
   localparam logic [7:0]  TGT_3 = 8'h50;
   localparam logic [15:0] GAIN_0 = 16'h0008;
   localparam logic [15:0] GAIN_1 = 16'h0010;
   localparam logic [15:0] GAIN_2 = 16'h0020;
   localparam logic [15:0] GAIN_3 = 16'h0040;
   localparam logic [7:0]  THR_1 = 8'h10;
   localparam logic [7:0]  THR_2 = 8'h20;
   localparam logic [7:0]  THR_3 = 8'h30;
   localparam logic [7:0]  THR_4 = 8'h40;
   localparam logic [7:0]  THR_5 = 8'h80;
   localparam logic [7:0]  THR_6 = 8'hC0;
   localparam logic [2:0]  THR_CODE_OFF = 3'h0;
   localparam logic [2:0]  THR_CODE_ON  = 3'h7;
   localparam logic [3:0]  FS_CUR_0 = 4'h2;
   localparam logic [3:0]  FS_CUR_1 = 4'h4;
   localparam logic [3:0]  FS_CUR_2 = 4'h6;
   localparam logic [3:0]  FS_CUR_3 = 4'h8;
   // Tolerance band = target >> 3 (12.5 %)
   localparam int          TOL_SHIFT = 3;
   localparam int          STRAP_W   = 20;
   // Full-step mode encoding
   localparam logic [1:0]  FS_MODE_OFF  = 2'h0;
   localparam logic [1:0]  FS_MODE_THR  = 2'h1;
   localparam logic [1:0]  FS_MODE_ON   = 2'h2;
endpackage

/* verilog/spd_sync.sv */
// Two-flop synchroniser for a vector of static strap pins.
// Assumes pins are quasi-static board tie-offs.
`timescale 1ns/1ps
`default_nettype none
module spd_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   // Data
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* verilog/spd_apb.sv */
// APB slave holding the serially written register bank.
// Assumes APB3 master on sys_clk; zero-wait answers.
`timescale 1ns/1ps
`default_nettype none
module spd_apb (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Register bank values
   output logic      [7:0]  bank_ampl,
   output logic      [7:0]  bank_step,
   output logic      [1:0]  bank_stdby,
   output logic      [7:0]  bank_reg_tgt,
   output logic      [15:0] bank_reg_gain,
   output logic      [7:0]  bank_fs_thrs,
   output logic      [3:0]  bank_fs_cur,
   output logic      [1:0]  bank_decay,
   // Readback of block state
   input  wire logic [31:0] status_rd,
   input  wire logic [31:0] straps_rd
);
   logic wr_en;
   logic setup;
   logic [31:0] rd_d;
   logic        hit;

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready && !pslverr;

   always_comb
   begin
      hit  = 1'b1;
      rd_d = '0;
      unique case (paddr)
         spd_pkg::ADDR_AMPL:     rd_d[7:0]  = bank_ampl;
         spd_pkg::ADDR_STEP:     rd_d[7:0]  = bank_step;
         spd_pkg::ADDR_STDBY:    rd_d[1:0]  = bank_stdby;
         spd_pkg::ADDR_REG_TGT:  rd_d[7:0]  = bank_reg_tgt;
         spd_pkg::ADDR_REG_GAIN: rd_d[15:0] = bank_reg_gain;
         spd_pkg::ADDR_FS_THRS:  rd_d[7:0]  = bank_fs_thrs;
         spd_pkg::ADDR_FS_CUR:   rd_d[3:0]  = bank_fs_cur;
         spd_pkg::ADDR_DECAY:    rd_d[1:0]  = bank_decay;
         spd_pkg::ADDR_STATUS:   rd_d       = status_rd;
         spd_pkg::ADDR_STRAPS:   rd_d       = straps_rd;
         default:                hit        = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------
   // Answer: no wait state, registered
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !hit;
         if (setup && !pwrite)
            prdata <= rd_d;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bank_ampl     <= spd_pkg::RST_AMPL;
         bank_step     <= spd_pkg::RST_STEP;
         bank_stdby    <= spd_pkg::RST_STDBY;
         bank_reg_tgt  <= spd_pkg::RST_REG_TGT;
         bank_reg_gain <= spd_pkg::RST_REG_GAIN;
         bank_fs_thrs  <= spd_pkg::RST_FS_THRS;
         bank_fs_cur   <= spd_pkg::RST_FS_CUR;
         bank_decay    <= spd_pkg::RST_DECAY;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            spd_pkg::ADDR_AMPL:     bank_ampl     <= pwdata[7:0];
            spd_pkg::ADDR_STEP:     bank_step     <= pwdata[7:0];
            spd_pkg::ADDR_STDBY:    bank_stdby    <= pwdata[1:0];
            spd_pkg::ADDR_REG_TGT:  bank_reg_tgt  <= pwdata[7:0];
            spd_pkg::ADDR_REG_GAIN: bank_reg_gain <= pwdata[15:0];
            spd_pkg::ADDR_FS_THRS:  bank_fs_thrs  <= pwdata[7:0];
            spd_pkg::ADDR_FS_CUR:   bank_fs_cur   <= pwdata[3:0];
            spd_pkg::ADDR_DECAY:    bank_decay    <= pwdata[1:0];
            default:                ;
         endcase
      end
   end
endmodule
`default_nettype wire

/* verilog/spd_strap_decoder.sv */
// Strap-pin motor configuration decoder: picks straps or register bank.
// Assumes strap pins are static tie-offs, asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Mode pin high: straps; low: register bank
// - Straps override covered settings; others stay
// - Suffix gives bit position; high reads 1
// - Amplitude nibble high, low nibble ones
// - Step code selects increment 1/4/16/64
// - Standby code scales amplitude and target
// - Target code zero disables regulator; 40/60/80
// - Strap mode tolerance fixed at 12.5 percent
// - Gain code selects 0x08 to 0x40
// - Threshold code: off, six thresholds, on
// - Forced full step keeps strapped increment
// - Full-step current code gives 2/4/6/8
// - Decay code gives 0/50/75/87.5 percent
module spd_strap_decoder (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Strap pins
   input  wire logic        strap_mode_sel,
   input  wire logic [3:0]  strap_amplitude_nibble,
   input  wire logic [1:0]  strap_step_increment,
   input  wire logic [1:0]  strap_standby_reduction,
   input  wire logic [1:0]  strap_regulator_target,
   input  wire logic [1:0]  strap_regulator_gain,
   input  wire logic [2:0]  strap_fullstep_threshold,
   input  wire logic [1:0]  strap_fullstep_current,
   input  wire logic [1:0]  strap_decay_fraction,
   // Effective settings
   output logic      [7:0]  cfg_amplitude_q,
   output logic      [7:0]  cfg_step_increment_q,
   output logic      [1:0]  cfg_standby_code_q,
   output logic             cfg_standby_active_q,
   output logic      [7:0]  cfg_reg_target_q,
   output logic             cfg_reg_enable_q,
   output logic      [7:0]  cfg_reg_tolerance_q,
   output logic      [15:0] cfg_reg_gain_q,
   output logic      [1:0]  cfg_fullstep_mode_q,
   output logic      [7:0]  cfg_fullstep_thrs_q,
   output logic      [3:0]  cfg_fullstep_current_q,
   output logic      [1:0]  decay_share_q,
   output logic             cfg_strap_mode_q
);
   // -----------------------------------------------------------------
   // Synchronisers
   // -----------------------------------------------------------------
   logic [spd_pkg::STRAP_W-1:0] strap_raw;
   logic [spd_pkg::STRAP_W-1:0] strap_s;
   logic                        mode_s;
   logic [3:0]                  s_ampl;
   logic [1:0]                  s_step;
   logic [1:0]                  s_stdby;
   logic [1:0]                  s_tgt;
   logic [1:0]                  s_gain;
   logic [2:0]                  s_thrs;
   logic [1:0]                  s_fscur;
   logic [1:0]                  s_decay;

   // Bit 0 of each group lands in the low bit of its field
   assign strap_raw = {strap_mode_sel, strap_amplitude_nibble, strap_step_increment,
                       strap_standby_reduction, strap_regulator_target,
                       strap_regulator_gain, strap_fullstep_threshold,
                       strap_fullstep_current, strap_decay_fraction};

   spd_sync #(
      .W (spd_pkg::STRAP_W)
   ) u_sync (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .pin_in   (strap_raw),
      .sync_out (strap_s)
   );

   assign {mode_s, s_ampl, s_step, s_stdby, s_tgt, s_gain, s_thrs, s_fscur, s_decay}
      = strap_s;

   // -----------------------------------------------------------------
   // Register bank
   // -----------------------------------------------------------------
   logic [7:0]  bank_ampl;
   logic [7:0]  bank_step;
   logic [1:0]  bank_stdby;
   logic [7:0]  bank_reg_tgt;
   logic [15:0] bank_reg_gain;
   logic [7:0]  bank_fs_thrs;
   logic [3:0]  bank_fs_cur;
   logic [1:0]  bank_decay;
   logic [31:0] status_rd;
   logic [31:0] straps_rd;

   assign status_rd = {15'h0000, cfg_strap_mode_q, cfg_reg_enable_q, cfg_standby_active_q,
                       cfg_fullstep_mode_q, cfg_fullstep_current_q, cfg_amplitude_q};
   assign straps_rd = {12'h000, strap_s};

   spd_apb u_apb (
      .sys_clk       (sys_clk),
      .nrst          (nrst),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .bank_ampl     (bank_ampl),
      .bank_step     (bank_step),
      .bank_stdby    (bank_stdby),
      .bank_reg_tgt  (bank_reg_tgt),
      .bank_reg_gain (bank_reg_gain),
      .bank_fs_thrs  (bank_fs_thrs),
      .bank_fs_cur   (bank_fs_cur),
      .bank_decay    (bank_decay),
      .status_rd     (status_rd),
      .straps_rd     (straps_rd)
   );

   // -----------------------------------------------------------------
   // Strap decode
   // -----------------------------------------------------------------
   logic [7:0]  dec_ampl;
   logic [7:0]  dec_step;
   logic [7:0]  dec_tgt;
   logic [15:0] dec_gain;
   logic [7:0]  dec_thrs;
   logic [1:0]  dec_fs_mode;
   logic [3:0]  dec_fscur;

   assign dec_ampl = {s_ampl, spd_pkg::AMPL_LOW_NIBBLE};

   always_comb
   begin
      unique case (s_step)
         2'h0: dec_step = spd_pkg::STEP_INC0;
         2'h1: dec_step = spd_pkg::STEP_INC1;
         2'h2: dec_step = spd_pkg::STEP_INC2;
         2'h3: dec_step = spd_pkg::STEP_INC3;
      endcase
      unique case (s_tgt)
         2'h0: dec_tgt = 8'h00;
         2'h1: dec_tgt = spd_pkg::TGT_1;
         2'h2: dec_tgt = spd_pkg::TGT_2;
         2'h3: dec_tgt = spd_pkg::TGT_3;
      endcase
      unique case (s_gain)
         2'h0: dec_gain = spd_pkg::GAIN_0;
         2'h1: dec_gain = spd_pkg::GAIN_1;
         2'h2: dec_gain = spd_pkg::GAIN_2;
         2'h3: dec_gain = spd_pkg::GAIN_3;
      endcase
      unique case (s_fscur)
         2'h0: dec_fscur = spd_pkg::FS_CUR_0;
         2'h1: dec_fscur = spd_pkg::FS_CUR_1;
         2'h2: dec_fscur = spd_pkg::FS_CUR_2;
         2'h3: dec_fscur = spd_pkg::FS_CUR_3;
      endcase
      dec_fs_mode = spd_pkg::FS_MODE_THR;
      unique case (s_thrs)
         3'h0: dec_thrs = 8'h00;
         3'h1: dec_thrs = spd_pkg::THR_1;
         3'h2: dec_thrs = spd_pkg::THR_2;
         3'h3: dec_thrs = spd_pkg::THR_3;
         3'h4: dec_thrs = spd_pkg::THR_4;
         3'h5: dec_thrs = spd_pkg::THR_5;
         3'h6: dec_thrs = spd_pkg::THR_6;
         3'h7: dec_thrs = 8'h00;
      endcase
      if (s_thrs == spd_pkg::THR_CODE_OFF)
         dec_fs_mode = spd_pkg::FS_MODE_OFF;
      else if (s_thrs == spd_pkg::THR_CODE_ON)
         dec_fs_mode = spd_pkg::FS_MODE_ON;
   end

   // -----------------------------------------------------------------
   // Source selection and standby scaling
   // -----------------------------------------------------------------
   logic [7:0] sel_ampl;
   logic [7:0] sel_tgt;
   logic [1:0] sel_stdby;
   logic       sel_stdby_act;
   logic [7:0] bank_fs_thr_v;
   logic [1:0] bank_fs_mode;

   // Bank mode: threshold 0 means off, no forced-on in bank
   assign bank_fs_thr_v = bank_fs_thrs;
   assign bank_fs_mode  = (bank_fs_thrs == 8'h00) ? spd_pkg::FS_MODE_OFF
                                                  : spd_pkg::FS_MODE_THR;

   assign sel_ampl      = mode_s ? dec_ampl : bank_ampl;
   assign sel_tgt       = mode_s ? dec_tgt  : bank_reg_tgt;
   assign sel_stdby     = mode_s ? s_stdby  : bank_stdby;
   // Standby acts while any bit of the selected standby code (straps or bank) is high
   assign sel_stdby_act = mode_s ? (s_stdby != 2'h0) : (bank_stdby != 2'h0);

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg_amplitude_q      <= '0;
         cfg_reg_target_q     <= '0;
         cfg_standby_code_q   <= '0;
         cfg_standby_active_q <= 1'b0;
      end
      else
      begin
         // Shift scales by 1, 0.5, 0.25, 0.125
         cfg_amplitude_q      <= sel_ampl >> sel_stdby;
         cfg_reg_target_q     <= sel_tgt >> sel_stdby;
         cfg_standby_code_q   <= sel_stdby;
         cfg_standby_active_q <= sel_stdby_act;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg_reg_enable_q    <= 1'b0;
         cfg_reg_tolerance_q <= '0;
         cfg_reg_gain_q      <= spd_pkg::RST_REG_GAIN;
      end
      else
      begin
         cfg_reg_enable_q    <= (sel_tgt != 8'h00);
         // Band taken from the unscaled target
         cfg_reg_tolerance_q <= sel_tgt >> spd_pkg::TOL_SHIFT;
         cfg_reg_gain_q      <= mode_s ? dec_gain : bank_reg_gain;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg_step_increment_q   <= spd_pkg::RST_STEP;
         cfg_fullstep_mode_q    <= spd_pkg::FS_MODE_OFF;
         cfg_fullstep_thrs_q    <= '0;
         cfg_fullstep_current_q <= spd_pkg::RST_FS_CUR;
         decay_share_q          <= spd_pkg::RST_DECAY;
         cfg_strap_mode_q       <= 1'b0;
      end
      else
      begin
         // Increment stays in force even when full step is forced on
         cfg_step_increment_q   <= mode_s ? dec_step : bank_step;
         cfg_fullstep_mode_q    <= mode_s ? dec_fs_mode : bank_fs_mode;
         cfg_fullstep_thrs_q    <= mode_s ? dec_thrs : bank_fs_thr_v;
         cfg_fullstep_current_q <= mode_s ? dec_fscur : bank_fs_cur;
         decay_share_q          <= mode_s ? s_decay : bank_decay;
         cfg_strap_mode_q       <= mode_s;
      end
   end
endmodule
`default_nettype wire

/* test/spd_board_ties.sv */
// Board tie-offs on the strap pins, set as one word by the bench.
// Assumes the word order mode, amplitude, step, standby, target, gain,
// threshold, full-step current, decay, most significant first.
`timescale 1ns/1ps
`default_nettype none
module spd_board_ties (
   // Selection
   input  wire logic [19:0] tie_word,
   // Strap pins
   output logic             strap_mode_sel,
   output logic      [3:0]  strap_amplitude_nibble,
   output logic      [1:0]  strap_step_increment,
   output logic      [1:0]  strap_standby_reduction,
   output logic      [1:0]  strap_regulator_target,
   output logic      [1:0]  strap_regulator_gain,
   output logic      [2:0]  strap_fullstep_threshold,
   output logic      [1:0]  strap_fullstep_current,
   output logic      [1:0]  strap_decay_fraction
);
   // Hard ties: lowest suffix is bit 0, a tie to supply reads 1
   assign {strap_mode_sel, strap_amplitude_nibble, strap_step_increment,
           strap_standby_reduction, strap_regulator_target, strap_regulator_gain,
           strap_fullstep_threshold, strap_fullstep_current,
           strap_decay_fraction} = tie_word;
endmodule
`default_nettype wire

/* test/spd_strap_decoder_sva.sv */
// Checker on the strap path of the decoder.
// Assumes the pin-to-output delay of three edges.
`timescale 1ns/1ps
`default_nettype none
module spd_strap_decoder_sva (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // Straps
   input wire logic        strap_mode_sel,
   input wire logic [3:0]  strap_amplitude_nibble,
   input wire logic [1:0]  strap_step_increment,
   input wire logic [1:0]  strap_standby_reduction,
   input wire logic [1:0]  strap_regulator_target,
   input wire logic [1:0]  strap_regulator_gain,
   input wire logic [2:0]  strap_fullstep_threshold,
   input wire logic [1:0]  strap_fullstep_current,
   input wire logic [1:0]  strap_decay_fraction,
   // Settings
   input wire logic [7:0]  cfg_amplitude_q,
   input wire logic [7:0]  cfg_step_increment_q,
   input wire logic [1:0]  cfg_standby_code_q,
   input wire logic        cfg_standby_active_q,
   input wire logic [7:0]  cfg_reg_target_q,
   input wire logic        cfg_reg_enable_q,
   input wire logic [7:0]  cfg_reg_tolerance_q,
   input wire logic [15:0] cfg_reg_gain_q,
   input wire logic [1:0]  cfg_fullstep_mode_q,
   input wire logic [7:0]  cfg_fullstep_thrs_q,
   input wire logic [3:0]  cfg_fullstep_current_q,
   input wire logic [1:0]  decay_share_q,
   input wire logic        cfg_strap_mode_q
);
   logic [2:0] live_q;
   logic [2:0] mode_q;
   logic       on_w;
   // Hold off until the synchronisers have flushed reset values
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         live_q <= 3'h0;
      else if (live_q != 3'h4)
         live_q <= live_q + 3'h1;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         mode_q <= 3'h0;
      else
         mode_q <= {mode_q[1:0], strap_mode_sel};
   assign on_w = (live_q == 3'h4) && mode_q[2];
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   mode_follow_a: assert property (live_q == 3'h4 |-> cfg_strap_mode_q == mode_q[2])
      else $error("mode flag does not follow mode pin");
   ampl_decode_a: assert property (on_w |-> cfg_amplitude_q ==
      ({$past(strap_amplitude_nibble, 3), 4'hF} >> $past(strap_standby_reduction, 3)))
      else $error("amplitude decode wrong");
   step_decode_a: assert property (on_w |->
      cfg_step_increment_q == (8'h01 << (2 * $past(strap_step_increment, 3))))
      else $error("step increment decode wrong");
   standby_flag_a: assert property (on_w |-> cfg_standby_code_q ==
      $past(strap_standby_reduction, 3) &&
      cfg_standby_active_q == ($past(strap_standby_reduction, 3) != 2'h0))
      else $error("standby code or flag wrong");
   reg_target_a: assert property (on_w |->
      cfg_reg_enable_q == ($past(strap_regulator_target, 3) != 2'h0) && cfg_reg_target_q ==
      (8'(8'h14 * $past(strap_regulator_target, 3) +
      ($past(strap_regulator_target, 3) != 2'h0 ? 8'h14 : 8'h00))
      >> $past(strap_standby_reduction, 3)))
      else $error("regulator target or enable wrong");
   tolerance_a: assert property (on_w |-> cfg_reg_tolerance_q ==
      8'(8'h14 * $past(strap_regulator_target, 3) +
      ($past(strap_regulator_target, 3) != 2'h0 ? 8'h14 : 8'h00)) >> 3)
      else $error("tolerance band wrong");
   gain_decode_a: assert property (on_w |->
      cfg_reg_gain_q == (16'h0008 << $past(strap_regulator_gain, 3)))
      else $error("gain decode wrong");
   fullstep_mode_a: assert property (on_w && $past(strap_fullstep_threshold, 3) == 3'h7
      |-> cfg_fullstep_mode_q == 2'h2 && cfg_fullstep_thrs_q == 8'h00)
      else $error("forced full step wrong");
   fullstep_off_a: assert property (on_w && $past(strap_fullstep_threshold, 3) == 3'h0
      |-> cfg_fullstep_mode_q == 2'h0)
      else $error("full step not off");
   fs_current_a: assert property (on_w |->
      cfg_fullstep_current_q == 4'(4'h2 + 4'h2 * $past(strap_fullstep_current, 3)))
      else $error("full step current wrong");
   decay_code_a: assert property (on_w |-> decay_share_q == $past(strap_decay_fraction, 3))
      else $error("decay code wrong");
endmodule
`default_nettype wire

/* test/spd_strap_decoder_bench.sv */
// Bench for the decoder: board ties as partner, APB for the bank.
// Assumes the pin-to-output delay of three edges and APB wait-free answers.
`timescale 1ns/1ps
`default_nettype none
module spd_strap_decoder_bench;
   logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err, sm;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] tie_word;
   logic [3:0]  s_amp, nb, cfg_fullstep_current_q;
   logic [2:0]  s_thr, kk;
   logic [1:0]  s_stp, s_sb, s_tgt, s_gn, s_fc, s_dc, c, s;
   logic [1:0]  cfg_standby_code_q, cfg_fullstep_mode_q, decay_share_q;
   logic        cfg_standby_active_q, cfg_reg_enable_q, cfg_strap_mode_q;
   logic [7:0]  cfg_amplitude_q, cfg_step_increment_q, cfg_reg_target_q;
   logic [7:0]  cfg_reg_tolerance_q, cfg_fullstep_thrs_q;
   logic [15:0] cfg_reg_gain_q;
   logic [7:0]  tgt_tab [4] = '{8'h00, 8'h28, 8'h3C, 8'h50};
   logic [7:0]  thr_tab [8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hC0, 8'h00};
   int          n_mismatch, check_count;
   spd_board_ties spd_board_ties_i (.tie_word(tie_word), .strap_mode_sel(sm),
      .strap_amplitude_nibble(s_amp), .strap_step_increment(s_stp),
      .strap_standby_reduction(s_sb), .strap_regulator_target(s_tgt),
      .strap_regulator_gain(s_gn), .strap_fullstep_threshold(s_thr),
      .strap_fullstep_current(s_fc), .strap_decay_fraction(s_dc));
   spd_strap_decoder spd_strap_decoder_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .strap_mode_sel(sm), .strap_amplitude_nibble(s_amp),
      .strap_step_increment(s_stp), .strap_standby_reduction(s_sb),
      .strap_regulator_target(s_tgt), .strap_regulator_gain(s_gn),
      .strap_fullstep_threshold(s_thr), .strap_fullstep_current(s_fc),
      .strap_decay_fraction(s_dc), .cfg_amplitude_q, .cfg_step_increment_q, .cfg_standby_code_q,
      .cfg_standby_active_q, .cfg_reg_target_q, .cfg_reg_enable_q, .cfg_reg_tolerance_q,
      .cfg_reg_gain_q, .cfg_fullstep_mode_q, .cfg_fullstep_thrs_q, .cfg_fullstep_current_q,
      .decay_share_q, .cfg_strap_mode_q);
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; a spare edge first keeps psel from two assignments at once
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      repeat (8)
      begin
         @(posedge sys_clk);
         if (pready === 1'b1)
            break;
      end
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial
   begin
      {nrst, psel, penable, pwrite, paddr, pwdata, tie_word} = '0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      // Every code of each two- and three-bit group, amplitude nibble from zero to all ones in eight steps
      for (int k = 0; k < 8; k++)
      begin
         kk = 3'(k);
         c = kk[1:0];
         s = c + 2'h1;
         nb = {kk, kk[0]};
         @(posedge sys_clk);
         tie_word <= {1'b1, nb, c, s, c, c, kk, c, c};
         repeat (4) @(posedge sys_clk);
         check(cfg_amplitude_q, {nb, 4'hF} >> s);
         check(cfg_step_increment_q, 8'h01 << (2 * c));
         check(cfg_reg_target_q, tgt_tab[c] >> s);
         check(cfg_reg_enable_q, c != 2'h0);
         check(cfg_reg_tolerance_q, tgt_tab[c] >> 3);
         check(cfg_reg_gain_q, 16'h0008 << c);
         check(cfg_fullstep_mode_q, kk == 3'h0 ? 2'h0 : kk == 3'h7 ? 2'h2 : 2'h1);
         check(cfg_fullstep_thrs_q, thr_tab[kk]);
         check(cfg_fullstep_current_q, 4'h2 + 4'h2 * c);
         check(decay_share_q, c);
         check(cfg_standby_active_q, s != 2'h0);
         check(cfg_strap_mode_q, 1'b1);
      end
      apb(1'b1, spd_pkg::ADDR_AMPL, 32'h0000005A);
      repeat (3) @(posedge sys_clk);
      check(cfg_amplitude_q, 8'hFF);
      apb(1'b0, spd_pkg::ADDR_AMPL, 32'h0);
      check(rd, 32'h0000005A);
      tie_word <= {1'b0, tie_word[18:0]};
      repeat (4) @(posedge sys_clk);
      check(cfg_amplitude_q, 8'h5A);
      check(cfg_strap_mode_q, 1'b0);
      apb(1'b1, spd_pkg::ADDR_STDBY, 32'h00000002);
      repeat (3) @(posedge sys_clk);
      check(cfg_amplitude_q, 8'h16);
      apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
      check({rd[16], rd[7:0]}, {1'b0, 8'h16});
      apb(1'b0, 8'h40, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      tie_word <= {1'b1, tie_word[18:0]};
      repeat (4) @(posedge sys_clk);
      check(cfg_amplitude_q, 8'hFF);
      apb(1'b0, spd_pkg::ADDR_STRAPS, 32'h0);
      check(rd, {12'h000, tie_word});
      tally_and_finish();
   end
endmodule
bind spd_strap_decoder spd_strap_decoder_sva spd_strap_decoder_sva_i (.sys_clk, .nrst,
   .strap_mode_sel, .strap_amplitude_nibble, .strap_step_increment, .strap_standby_reduction,
   .strap_regulator_target, .strap_regulator_gain, .strap_fullstep_threshold,
   .strap_fullstep_current, .strap_decay_fraction, .cfg_amplitude_q, .cfg_step_increment_q,
   .cfg_standby_code_q, .cfg_standby_active_q, .cfg_reg_target_q, .cfg_reg_enable_q,
   .cfg_reg_tolerance_q, .cfg_reg_gain_q, .cfg_fullstep_mode_q, .cfg_fullstep_thrs_q,
   .cfg_fullstep_current_q, .decay_share_q, .cfg_strap_mode_q);
`default_nettype wire
